/* File: drive_input_pkg.sv */
// Constants, codes and carriers for the two-terminal input decoder.
// Assumes a single 100 MHz control clock and an AXI4-Lite register port.
package drive_input_pkg;

  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int PULSE_MS = 500;
  localparam int SEC_MS = 1000;
  localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
  localparam int SEC_CYC = SEC_MS * (CLK_HZ / 1000);

  // Frequencies in 0.01 Hz units, then duration and count reset values
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [15:0] FREQ_INC = 16'h0001;
  localparam logic [15:0] DUR_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // Terminal function codes
  typedef enum logic [4:0] {
    FN_NONE = 5'h00, FN_FWD_REV = 5'h01, FN_RUN_DIR = 5'h02,
    FN_FAULT_NO = 5'h04, FN_FAULT_NC = 5'h05, FN_RESET = 5'h06,
    FN_SPD1 = 5'h07, FN_SPD2 = 5'h08, FN_JOG = 5'h09, FN_INHIBIT = 5'h0A,
    FN_RAMP_SEL = 5'h0B, FN_BB_NO = 5'h0C, FN_BB_NC = 5'h0D, FN_UP = 5'h0E,
    FN_DOWN = 5'h0F, FN_SEQ_RUN = 5'h10, FN_SEQ_PAUSE = 5'h11,
    FN_COUNT = 5'h12, FN_COUNT_CLR = 5'h13
  } func_e;

  // Sequencer modes
  typedef enum logic [2:0] {
    SM_OFF = 3'h0, SM_ONCE = 3'h1, SM_LOOP = 3'h2, SM_STEP_ONCE = 3'h3,
    SM_STEP_LOOP = 3'h4
  } seq_mode_e;

  // Configuration word
  typedef struct packed {
    logic fwdrev_app;
    logic anti_slope;
    logic [2:0] seq_mode;
    logic [4:0] func;
  } cfg_s;

  localparam cfg_s CFG_RST = 10'h001;

  // Status word
  typedef struct packed {
    logic [10:0] rsvd;
    logic [1:0] seq_step;
    logic seq_busy;
    logic cleared;
    logic fault;
    logic [15:0] count;
  } status_s;

  // Register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STEP1 = 8'h04;
  localparam logic [7:0] ADDR_STEP2 = 8'h08;
  localparam logic [7:0] ADDR_STEP3 = 8'h0C;
  localparam logic [7:0] ADDR_MASTER = 8'h10;
  localparam logic [7:0] ADDR_DUR0 = 8'h14;
  localparam logic [7:0] ADDR_DUR3 = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : drive_input_pkg

/* File: drive_input_terminal_decoder.sv */
// Decoder for two programmable input terminals, step speeds and sequencer.
// Assumes pins are asynchronous; ramp and motor status come from CLK logic.
`timescale 1ns/1ps

// Functional notes
// R1: Function code zero makes the terminals have no effect at all.
// R2: Code 1 gives forward/reverse run; code 2 gives run plus direction.
// R3: Codes 4/5 external fault cuts output until cleared and reset.
// R4: Code 6 terminal resets exactly like the keypad reset key.
// R5: Codes 7/8 make both terminals step-speed select lines.
// R6: Select lines decode binary: 0 master, 1..3 step speeds.
// R7: Jog starts only when stopped; release stops with jog deceleration.
// R8: Code 10 holds the ramp only while accelerating or decelerating.
// R9: Code 11 picks ramp pair; change ignored at constant speed.
// R10: Codes 12/13 block output; release starts speed search.
// R11: Codes 14/15 step master frequency per pulse; no run implied.
// R12: Last up/down frequency is kept in nonvolatile storage.
// R13: Code 16 runs the sequencer, code 17 pauses it.
// R14: Code 18 counts each trigger exactly once.
// R15: Code 19 clears count; no counting while cleared indication shows.
// R16: Three step speeds, 0 to 400.00 Hz, reset value zero.
// R17: Sequencer modes 0 off, 1 once, 2 loop, 3/4 stepped variants.
// R18: Forward/reverse analog application ignores terminal run commands.
// R19: Anti-slope feedback lowers speed, never reverses it.
// R20: Step and cycle completion pulses last half a second.
// R21: Sequencer steps with zero duration are skipped.
module drive_input_terminal_decoder #(
  parameter int PULSE_CYC_P = drive_input_pkg::PULSE_CYC,
  parameter int SEC_CYC_P = drive_input_pkg::SEC_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Terminals and keypad
  input wire logic PROGRAMMABLE_INPUT_A,
  input wire logic PROGRAMMABLE_INPUT_B,
  input wire logic KEY_RESET,
  // Drive status
  input wire logic MOTOR_STOPPED,
  input wire logic RAMPING,
  input wire logic [15:0] ANALOG_FB,
  input wire logic [15:0] NV_FREQ,
  // Drive commands
  output logic RUN_FWD,
  output logic RUN_REV,
  output logic JOG_ACTIVE,
  output logic JOG_DECEL,
  output logic RAMP_HOLD,
  output logic RAMP_SEL2,
  output logic OUTPUT_CUT,
  output logic FAULT_ACTIVE,
  output logic FAULT_RESET,
  output logic SPEED_SEARCH,
  output logic [15:0] SPEED_CMD,
  output logic NV_WRITE,
  output logic [15:0] NV_DATA,
  output logic COUNTER_CLEARED_INDICATION,
  output logic STEP_DONE,
  output logic CYCLE_DONE,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  typedef enum logic [1:0] {
    SQ_IDLE = 2'h0, SQ_RUN = 2'h1, SQ_GAP = 2'h2, SQ_DONE = 2'h3
  } seq_e;

  localparam logic [15:0] DUR_ZERO = 16'h0000;
  localparam logic [15:0] FREQ_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] clamp_freq(input logic [15:0] f);
    return (f > drive_input_pkg::FREQ_MAX) ? drive_input_pkg::FREQ_MAX : f;
  endfunction : clamp_freq

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= drive_input_pkg::ADDR_STATUS);
  endfunction : mapped

  drive_input_pkg::cfg_s cfg_reg;
  logic [15:0] step_reg [1:3];
  logic [15:0] dur_reg [0:3];
  logic [15:0] master_reg;
  logic [15:0] count_reg;
  logic [2:0] s1_reg, s2_reg, prev_reg;
  logic fault_reg, bb_prev_reg, nv_init_reg, run_req_reg;
  logic wr_en, ta, tb, b_rise, b_fall, rst_evt, ext_fault, bb_on;
  logic [15:0] base_freq, wr_low;
  logic [31:0] wr_word;
  logic [1:0] sel_idx;
  seq_e seq_reg;
  logic [1:0] seq_step_reg;
  logic [15:0] seq_secs_reg;
  logic [31:0] sec_cnt_reg;
  logic [31:0] pcnt_reg [0:1];
  logic [1:0] ptrig;
  logic sec_tick, seq_pause, step_end, stepped, looping;

  // Two-flop synchronisers, edges taken from the second stage only
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      prev_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {KEY_RESET, PROGRAMMABLE_INPUT_B, PROGRAMMABLE_INPUT_A};
      s2_reg <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  assign ta = s2_reg[0];
  assign tb = s2_reg[1];
  assign b_rise = tb && !prev_reg[1];
  assign b_fall = !tb && prev_reg[1];

  // R4: keypad and terminal share one reset
  assign rst_evt = (s2_reg[2] && !prev_reg[2]) || (cfg_reg.func == drive_input_pkg::FN_RESET && b_rise);
  // R3: fault polarity per contact type
  assign ext_fault = (cfg_reg.func == drive_input_pkg::FN_FAULT_NO && tb) ||
                     (cfg_reg.func == drive_input_pkg::FN_FAULT_NC && !tb);
  // R10: block polarity per contact type
  assign bb_on = (cfg_reg.func == drive_input_pkg::FN_BB_NO && tb) ||
                 (cfg_reg.func == drive_input_pkg::FN_BB_NC && !tb);

  // AXI write path: both channels are taken in the same cycle
  assign wr_en = S_AXI_AWREADY;
  assign wr_word = merge(32'h0000_0000, S_AXI_WDATA, S_AXI_WSTRB);
  assign wr_low = wr_word[15:0];

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= drive_input_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
      if (wr_en)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(S_AXI_AWADDR) ? drive_input_pkg::RESP_OKAY
                                            : drive_input_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // Configuration, step speeds and durations
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cfg_reg <= drive_input_pkg::CFG_RST;
      for (int i = 1; i <= 3; i++)
        step_reg[i] <= drive_input_pkg::FREQ_RST;
      for (int i = 0; i <= 3; i++)
        dur_reg[i] <= drive_input_pkg::DUR_RST;
    end
    else if (wr_en)
    begin
      if (S_AXI_AWADDR == drive_input_pkg::ADDR_CFG)
        cfg_reg <= 10'(merge({22'h0, cfg_reg}, S_AXI_WDATA, S_AXI_WSTRB));
      // R16: step speeds limited to 400.00 Hz
      if (S_AXI_AWADDR == drive_input_pkg::ADDR_STEP1)
        step_reg[1] <= clamp_freq(16'(merge({16'h0, step_reg[1]}, S_AXI_WDATA, S_AXI_WSTRB)));
      if (S_AXI_AWADDR == drive_input_pkg::ADDR_STEP2)
        step_reg[2] <= clamp_freq(16'(merge({16'h0, step_reg[2]}, S_AXI_WDATA, S_AXI_WSTRB)));
      if (S_AXI_AWADDR == drive_input_pkg::ADDR_STEP3)
        step_reg[3] <= clamp_freq(16'(merge({16'h0, step_reg[3]}, S_AXI_WDATA, S_AXI_WSTRB)));
      for (int i = 0; i <= 3; i++)
      begin
        if (S_AXI_AWADDR == drive_input_pkg::ADDR_DUR0 + 8'(4 * i))
          dur_reg[i] <= 16'(merge({16'h0, dur_reg[i]}, S_AXI_WDATA, S_AXI_WSTRB));
      end
    end
  end

  // Master frequency, restored from storage after reset
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      master_reg <= drive_input_pkg::FREQ_RST;
      nv_init_reg <= 1'b0;
      NV_WRITE <= 1'b0;
    end
    else
    begin
      nv_init_reg <= 1'b1;
      NV_WRITE <= 1'b0;
      if (!nv_init_reg)
        master_reg <= clamp_freq(NV_FREQ);
      else if (wr_en && S_AXI_AWADDR == drive_input_pkg::ADDR_MASTER)
        master_reg <= clamp_freq(wr_low);
      // R11: one increment per pulse, no run command implied
      else if (b_rise && cfg_reg.func == drive_input_pkg::FN_UP)
      begin
        master_reg <= clamp_freq(master_reg + drive_input_pkg::FREQ_INC);
        // R12: each up/down step goes to storage
        NV_WRITE <= 1'b1;
      end
      else if (b_rise && cfg_reg.func == drive_input_pkg::FN_DOWN)
      begin
        master_reg <= (master_reg < drive_input_pkg::FREQ_INC) ? drive_input_pkg::FREQ_RST
                                                               : master_reg - drive_input_pkg::FREQ_INC;
        NV_WRITE <= 1'b1;
      end
    end
  end

  assign NV_DATA = master_reg;

  // R3: fault latch, raise wins over reset while the input stands
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      fault_reg <= 1'b0;
    else if (ext_fault)
      fault_reg <= 1'b1;
    else if (rst_evt)
      fault_reg <= 1'b0;
  end

  // Run, jog, ramp and block commands
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      RUN_FWD <= 1'b0;
      RUN_REV <= 1'b0;
      JOG_ACTIVE <= 1'b0;
      JOG_DECEL <= 1'b0;
      RAMP_HOLD <= 1'b0;
      RAMP_SEL2 <= 1'b0;
      OUTPUT_CUT <= 1'b0;
      FAULT_ACTIVE <= 1'b0;
      FAULT_RESET <= 1'b0;
      SPEED_SEARCH <= 1'b0;
      bb_prev_reg <= 1'b0;
    end
    else
    begin
      // R1: code zero matches no branch below
      // R2: two-wire decoding
      // R18: analog direction application masks terminal runs
      RUN_FWD <= !fault_reg && !cfg_reg.fwdrev_app &&
                 ((cfg_reg.func == drive_input_pkg::FN_FWD_REV && ta && !tb) ||
                  (cfg_reg.func == drive_input_pkg::FN_RUN_DIR && ta && !tb));
      RUN_REV <= !fault_reg && !cfg_reg.fwdrev_app &&
                 ((cfg_reg.func == drive_input_pkg::FN_FWD_REV && tb && !ta) ||
                  (cfg_reg.func == drive_input_pkg::FN_RUN_DIR && ta && tb));
      // R7: jog accepted only from standstill
      JOG_DECEL <= 1'b0;
      if (cfg_reg.func != drive_input_pkg::FN_JOG || !tb || fault_reg)
      begin
        JOG_DECEL <= JOG_ACTIVE;
        JOG_ACTIVE <= 1'b0;
      end
      else if (b_rise && MOTOR_STOPPED)
        JOG_ACTIVE <= 1'b1;
      // R8: hold only during a ramp
      RAMP_HOLD <= cfg_reg.func == drive_input_pkg::FN_INHIBIT && tb && RAMPING;
      // R9: ramp pair follows terminal only while ramping
      if (RAMPING)
        RAMP_SEL2 <= cfg_reg.func == drive_input_pkg::FN_RAMP_SEL && tb;
      OUTPUT_CUT <= fault_reg || bb_on;
      FAULT_ACTIVE <= fault_reg;
      FAULT_RESET <= rst_evt;
      // R10: speed search when the block lifts
      bb_prev_reg <= bb_on;
      SPEED_SEARCH <= bb_prev_reg && !bb_on;
    end
  end

  // Event counter
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      count_reg <= drive_input_pkg::COUNT_RST;
      COUNTER_CLEARED_INDICATION <= 1'b0;
    end
    // R15: clear and show indication while asserted
    else if (cfg_reg.func == drive_input_pkg::FN_COUNT_CLR && tb)
    begin
      count_reg <= drive_input_pkg::COUNT_RST;
      COUNTER_CLEARED_INDICATION <= 1'b1;
    end
    else
    begin
      COUNTER_CLEARED_INDICATION <= 1'b0;
      // R14: one count per rising edge
      if (cfg_reg.func == drive_input_pkg::FN_COUNT && b_rise && !COUNTER_CLEARED_INDICATION)
        count_reg <= count_reg + 16'h0001;
    end
  end

  // Sequencer run request; function change does not stop a running cycle
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      run_req_reg <= 1'b0;
    else if (cfg_reg.seq_mode == drive_input_pkg::SM_OFF)
      run_req_reg <= 1'b0;
    else if (cfg_reg.func == drive_input_pkg::FN_SEQ_RUN && b_rise)
      run_req_reg <= 1'b1;
    else if (cfg_reg.func == drive_input_pkg::FN_SEQ_RUN && b_fall)
      run_req_reg <= 1'b0;
  end

  // R13: pause freezes the step timer
  assign seq_pause = cfg_reg.func == drive_input_pkg::FN_SEQ_PAUSE && tb;
  assign sec_tick = sec_cnt_reg == 32'(SEC_CYC_P - 1);
  // R21: zero duration ends the step at once
  assign step_end = seq_reg == SQ_RUN && !seq_pause &&
                    (dur_reg[seq_step_reg] == DUR_ZERO || (sec_tick && seq_secs_reg + 16'h0001 >= dur_reg[seq_step_reg]));
  // R17: mode decoding
  assign stepped = cfg_reg.seq_mode == drive_input_pkg::SM_STEP_ONCE ||
                   cfg_reg.seq_mode == drive_input_pkg::SM_STEP_LOOP;
  assign looping = cfg_reg.seq_mode == drive_input_pkg::SM_LOOP ||
                   cfg_reg.seq_mode == drive_input_pkg::SM_STEP_LOOP;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      seq_reg <= SQ_IDLE;
      seq_step_reg <= 2'h0;
      seq_secs_reg <= 16'h0000;
      sec_cnt_reg <= 32'h0000_0000;
      ptrig <= 2'h0;
    end
    else
    begin
      ptrig <= 2'h0;
      if ((seq_reg == SQ_RUN && !seq_pause) || seq_reg == SQ_GAP)
        sec_cnt_reg <= sec_tick ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
      else if (seq_reg != SQ_RUN)
        sec_cnt_reg <= 32'h0000_0000;
      if (!run_req_reg)
        seq_reg <= SQ_IDLE;
      else
      begin
        unique case (seq_reg)
          SQ_IDLE:
          begin
            seq_reg <= SQ_RUN;
            seq_step_reg <= 2'h0;
            seq_secs_reg <= 16'h0000;
          end
          SQ_RUN:
          begin
            if (sec_tick && !seq_pause)
              seq_secs_reg <= seq_secs_reg + 16'h0001;
            if (step_end)
            begin
              seq_secs_reg <= 16'h0000;
              ptrig[0] <= dur_reg[seq_step_reg] != DUR_ZERO;
              ptrig[1] <= seq_step_reg == 2'h3;
              seq_step_reg <= seq_step_reg + 2'h1;
              if (seq_step_reg == 2'h3 && !looping)
                seq_reg <= SQ_DONE;
              else if (stepped)
                seq_reg <= SQ_GAP;
            end
          end
          // Stepped modes rest at zero speed for one second
          SQ_GAP:
          begin
            if (sec_tick)
              seq_reg <= SQ_RUN;
          end
          SQ_DONE:
          begin
            seq_reg <= SQ_DONE;
          end
        endcase
      end
    end
  end

  // R20: half-second completion pulses
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      STEP_DONE <= 1'b0;
      CYCLE_DONE <= 1'b0;
      pcnt_reg[0] <= 32'h0000_0000;
      pcnt_reg[1] <= 32'h0000_0000;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (ptrig[i])
          pcnt_reg[i] <= 32'h0000_0001;
        else if (pcnt_reg[i] != 32'h0000_0000)
          pcnt_reg[i] <= (pcnt_reg[i] == 32'(PULSE_CYC_P)) ? 32'h0000_0000
                                                          : pcnt_reg[i] + 32'h0000_0001;
      end
      STEP_DONE <= ptrig[0] || (pcnt_reg[0] != 32'h0000_0000 && pcnt_reg[0] != 32'(PULSE_CYC_P));
      CYCLE_DONE <= ptrig[1] || (pcnt_reg[1] != 32'h0000_0000 && pcnt_reg[1] != 32'(PULSE_CYC_P));
    end
  end

  // R5: both terminals become select lines
  // R6: binary index, line A is the low bit
  assign sel_idx = (cfg_reg.func == drive_input_pkg::FN_SPD1 ||
                    cfg_reg.func == drive_input_pkg::FN_SPD2) ? {tb, ta} : 2'h0;

  always_comb
  begin
    if (seq_reg == SQ_RUN)
      base_freq = (seq_step_reg == 2'h0) ? master_reg : step_reg[seq_step_reg];
    else if (seq_reg == SQ_GAP)
      base_freq = FREQ_ZERO;
    else
      base_freq = (sel_idx == 2'h0) ? master_reg : step_reg[sel_idx];
  end

  // R19: feedback subtracts and clamps at zero, so no reversal
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      SPEED_CMD <= FREQ_ZERO;
    else if (cfg_reg.anti_slope)
      SPEED_CMD <= (base_freq > ANALOG_FB) ? base_freq - ANALOG_FB : FREQ_ZERO;
    else
      SPEED_CMD <= base_freq;
  end

  // Read path
  drive_input_pkg::status_s status;
  always_comb
  begin
    status = '0;
    status.seq_step = seq_step_reg;
    status.seq_busy = seq_reg != SQ_IDLE;
    status.cleared = COUNTER_CLEARED_INDICATION;
    status.fault = fault_reg;
    status.count = count_reg;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= drive_input_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? drive_input_pkg::RESP_OKAY
                                            : drive_input_pkg::RESP_SLVERR;
        S_AXI_RDATA <= 32'h0000_0000;
        if (S_AXI_ARADDR == drive_input_pkg::ADDR_CFG)
          S_AXI_RDATA <= {22'h0, cfg_reg};
        else if (S_AXI_ARADDR == drive_input_pkg::ADDR_MASTER)
          S_AXI_RDATA <= {16'h0, master_reg};
        else if (S_AXI_ARADDR == drive_input_pkg::ADDR_STATUS)
          S_AXI_RDATA <= status;
        else if (S_AXI_ARADDR >= drive_input_pkg::ADDR_DUR0 && S_AXI_ARADDR <= drive_input_pkg::ADDR_DUR3)
          S_AXI_RDATA <= {16'h0, dur_reg[2'(S_AXI_ARADDR[7:2] - 6'h05)]};
        else if (S_AXI_ARADDR >= drive_input_pkg::ADDR_STEP1 && S_AXI_ARADDR <= drive_input_pkg::ADDR_STEP3)
          S_AXI_RDATA <= {16'h0, step_reg[2'(S_AXI_ARADDR[3:2])]};
      end
      else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // Checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [31:0] len_reg;
  always_ff @(posedge CLK)
    len_reg <= STEP_DONE ? len_reg + 32'h0000_0001 : 32'h0000_0000;

  chk_off_inert: assert property ($past(cfg_reg.func) == drive_input_pkg::FN_NONE |-> !RUN_FWD && !RUN_REV && !RAMP_HOLD) // R1
    else $error("terminal active with function zero");
  chk_run_decode: assert property (RUN_FWD |-> $past(ta && !tb && !fault_reg)) // R2
    else $error("forward run without its terminal state");
  chk_fault_cut: assert property (fault_reg |=> OUTPUT_CUT && !RUN_FWD && !RUN_REV) // R3
    else $error("fault did not cut output");
  chk_jog_stopped: assert property ($rose(JOG_ACTIVE) |-> $past(MOTOR_STOPPED)) // R7
    else $error("jog started while moving");
  chk_hold_ramp: assert property (RAMP_HOLD |-> $past(RAMPING)) // R8
    else $error("ramp hold outside a ramp");
  chk_count_step: assert property (count_reg != $past(count_reg) && count_reg != COUNT_ZERO |-> count_reg == $past(count_reg) + 16'h0001) // R14
    else $error("counter moved by more than one");
  chk_cleared_zero: assert property (COUNTER_CLEARED_INDICATION |-> count_reg == COUNT_ZERO ##1 count_reg == COUNT_ZERO) // R15
    else $error("count not zero while cleared");
  chk_speed_floor: assert property (cfg_reg.anti_slope && $past(cfg_reg.anti_slope) |-> SPEED_CMD <= $past(base_freq)) // R19
    else $error("feedback raised speed");
  chk_pulse_len: assert property ($fell(STEP_DONE) |-> $past(len_reg) == 32'(PULSE_CYC_P - 1)) // R20
    else $error("step pulse has wrong length");

  cov_jog: cover property ($rose(JOG_ACTIVE));
  cov_cycle: cover property ($rose(CYCLE_DONE));
  cov_search: cover property ($fell(OUTPUT_CUT) && SPEED_SEARCH);
  cov_clear: cover property ($fell(COUNTER_CLEARED_INDICATION));

endmodule : drive_input_terminal_decoder

/* File: contact_model.sv */
// Model of the switches, contacts and keypad key wired to the terminals.
// Assumes the bench sets contact states; pins move only after a CLK edge.
`timescale 1ns/1ps
module contact_model (
  // Clock
  input wire logic clk,
  // Requested contact states
  input wire logic a_on,
  input wire logic b_on,
  input wire logic key_on,
  // Pins
  output logic pin_a,
  output logic pin_b,
  output logic pin_key
);
  // Bounce-free contacts, so every change reaches the pins whole
  always_ff @(posedge clk) {pin_a, pin_b, pin_key} <= {a_on, b_on, key_on};
endmodule : contact_model

/* File: tb.sv */
// Self-checking bench for the terminal decoder and its register port.
// Assumes the contact model drives the pins; motor status is set directly by the bench.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb;
  logic clk = 0, rst_n = 0, a_on = 0, b_on = 0, pa, pb, pk, fwd, rev, clr;
  logic key_on = 0, stopped = 1, ramp = 0, flt, cut, hold, jog, sd, cd;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, awready, wready, bvalid;
  logic arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, rdata;
  logic [1:0] rs, bresp, rresp;
  logic [15:0] spd;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  contact_model sw (.clk(clk), .a_on(a_on), .b_on(b_on), .key_on(key_on), .pin_a(pa),
    .pin_b(pb), .pin_key(pk));
  drive_input_terminal_decoder #(.PULSE_CYC_P(20), .SEC_CYC_P(10)) dut (.CLK(clk),
    .RST_N(rst_n), .PROGRAMMABLE_INPUT_A(pa), .PROGRAMMABLE_INPUT_B(pb), .KEY_RESET(pk),
    .MOTOR_STOPPED(stopped), .RAMPING(ramp), .ANALOG_FB(16'h0000), .NV_FREQ(16'h0123),
    .RUN_FWD(fwd), .RUN_REV(rev), .JOG_ACTIVE(jog), .JOG_DECEL(), .RAMP_HOLD(hold), .RAMP_SEL2(),
    .OUTPUT_CUT(cut), .FAULT_ACTIVE(flt), .FAULT_RESET(), .SPEED_SEARCH(), .SPEED_CMD(spd),
    .NV_WRITE(), .NV_DATA(), .COUNTER_CLEARED_INDICATION(clr), .STEP_DONE(sd), .CYCLE_DONE(cd),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end
  // Pin to output path is about five cycles, so eight is safe
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awv, wv} <= {a, d, 2'b11};
    do @(negedge clk); while (!(awready && wready));
    @(posedge clk);
    {awv, wv, bready} <= 3'b001;
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr
  task automatic rdt(input logic [7:0] a);
    @(posedge clk);
    {araddr, arv} <= {a, 1'b1};
    do @(negedge clk); while (!arready);
    @(posedge clk);
    {arv, rready} <= 2'b01;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    {rd, rs} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rdt
  task automatic t_regs;
    rdt(drive_input_pkg::ADDR_CFG);
    `CHK("mode", 3'h0, rd[7:5])
    rdt(drive_input_pkg::ADDR_STEP1);
    `CHK("step1", 32'h0, rd)
    wr(drive_input_pkg::ADDR_STEP1, 32'hFFFF);
    rdt(drive_input_pkg::ADDR_STEP1);
    `CHK("clamp", 32'h9C40, rd)
    rdt(8'h40);
    `CHK("resp", drive_input_pkg::RESP_SLVERR, rs)
  endtask : t_regs
  task automatic t_steps;
    for (int i = 1; i < 4; i++) wr(8'(4 * i), 32'(i * 256));
    wr(drive_input_pkg::ADDR_CFG, 32'h7);
    for (int i = 0; i < 4; i++)
    begin
      {b_on, a_on} <= 2'(i);
      settle();
      `CHK("speed", (i == 0) ? 16'h0123 : 16'(i * 256), spd)
    end
    {b_on, a_on} <= 2'b00;
    settle();
  endtask : t_steps
  task automatic t_count;
    wr(drive_input_pkg::ADDR_CFG, 32'h12);
    repeat (3)
    begin
      b_on <= 1'b1;
      settle();
      b_on <= 1'b0;
      settle();
    end
    rdt(drive_input_pkg::ADDR_STATUS);
    `CHK("count", 16'h0003, rd[15:0])
    wr(drive_input_pkg::ADDR_CFG, 32'h13);
    b_on <= 1'b1;
    settle();
    rdt(drive_input_pkg::ADDR_STATUS);
    `CHK("cleared", 1'b1, clr)
    `CHK("zero", 16'h0000, rd[15:0])
    b_on <= 1'b0;
    settle();
  endtask : t_count
  task automatic t_run;
    wr(drive_input_pkg::ADDR_CFG, 32'h0);
    {a_on, b_on} <= 2'b11;
    settle();
    `CHK("idle", 2'b00, {fwd, rev})
    wr(drive_input_pkg::ADDR_CFG, 32'h2);
    settle();
    `CHK("rundir", 2'b01, {fwd, rev})
    wr(drive_input_pkg::ADDR_CFG, 32'h1);
    b_on <= 1'b0;
    settle();
    `CHK("fwdrun", 2'b10, {fwd, rev})
  endtask : t_run
  task automatic t_fault;
    wr(drive_input_pkg::ADDR_CFG, 32'h4);
    b_on <= 1'b1;
    settle();
    `CHK("fault", 2'b11, {flt, cut})
    b_on <= 1'b0;
    settle();
    `CHK("latched", 1'b1, flt)
    key_on <= 1'b1;
    settle();
    `CHK("keyrst", 1'b0, flt)
    key_on <= 1'b0;
  endtask : t_fault
  task automatic t_motion;
    wr(drive_input_pkg::ADDR_CFG, 32'hA);
    {b_on, ramp} <= 2'b11;
    settle();
    `CHK("hold", 1'b1, hold)
    ramp <= 1'b0;
    settle();
    `CHK("nohold", 1'b0, hold)
    wr(drive_input_pkg::ADDR_CFG, 32'h9);
    {b_on, stopped} <= 2'b00;
    settle();
    b_on <= 1'b1;
    settle();
    `CHK("jogmove", 1'b0, jog)
    {b_on, stopped} <= 2'b01;
    settle();
    b_on <= 1'b1;
    settle();
    `CHK("jog", 1'b1, jog)
    b_on <= 1'b0;
    settle();
  endtask : t_motion
  // Step 0 lasts one second, zero-length steps 1..3 are skipped
  task automatic t_seq;
    wr(drive_input_pkg::ADDR_DUR0, 32'h1);
    wr(drive_input_pkg::ADDR_CFG, 32'h30);
    b_on <= 1'b1;
    repeat (24) @(posedge clk);
    `CHK("done", 2'b11, {sd, cd})
    repeat (20) @(posedge clk);
    `CHK("ended", 2'b00, {sd, cd})
    b_on <= 1'b0;
    settle();
  endtask : t_seq
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_steps();
    t_count();
    t_run();
    t_fault();
    t_motion();
    t_seq();
    test_done();
  end
endmodule : tb
